// ### src/low_power_mode_control.sv
// Power-mode controller: APB registers, standby sequencer, wake logic.
`timescale 1ns/1ps
// Summary of operation
// R1 - Mode field picks high, low one, low two
// R2 - Software keeps clocks under each mode ceiling
// R3 - Low code always taken; saves if clocks fit
// R4 - Software programs largest clock dividers
// R5 - Standby entered by control register plus wait
// R6 - Interrupt or reset exits; deep exits via reset
// R7 - Software clears pending requests and enable first
// R8 - CPU stopped in every standby mode
// R9 - Fast oscillators and PLL stop in software standby
// R10 - RAM usable in sleep, retained mid; deep loses RAM1, and RAM0 unless kept
// R11 - Peripherals stop beyond sleep; pins hold
// R12 - Monitors, reset detector, clock stay alive
// R13 - Watchdogs and timers frozen per mode
// R14 - Taking interrupt clears global interrupt enable
module low_power_mode_control (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lpm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_exec,
  input wire logic irq_req,
  input wire logic gie,
  input wire logic ls1_clk_ok,
  input wire logic ls2_clk_ok,
  output logic [2:0] power_mode_q,
  output logic lp_effective_q,
  output logic flash_pe_inhibit_q,
  output logic irq_accept_q,
  output logic gie_clear_q,
  output logic deep_reset_req_q,
  output logic cpu_stop,
  output logic hoco_stop,
  output logic loco_stop,
  output logic pll_stop,
  output logic ram1_stop,
  output logic ram0_stop,
  output logic ram1_lost,
  output logic ram0_lost,
  output logic periph_stop,
  output logic io_hold,
  output logic system_watchdog_freeze,
  output logic independent_watchdog_stop,
  output logic eight_bit_timer_freeze,
  output logic monitors_on
);
  import lpm_pkg::*;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [1:0] sby_sel_q;
  logic ram0_keep_q;
  pm_state_t state_q;
  pm_state_t state_d;

  wire logic setup = psel && !penable;
  wire logic commit = psel && penable && pready;
  wire logic hit_opc = (paddr == OFS_OPC);
  wire logic hit_sby = (paddr == OFS_SBY);
  wire logic hit_stat = (paddr == OFS_STAT);
  wire logic mapped = hit_opc || hit_sby || hit_stat;
  wire logic wr_opc = commit && pwrite && hit_opc;
  wire logic wr_sby = commit && pwrite && hit_sby;
  wire logic [2:0] new_mode = pwdata[OPC_MODE_LSB +: 3];
  wire logic mode_legal = (new_mode == MODE_HS) || (new_mode == MODE_LS1)
                       || (new_mode == MODE_LS2);
  wire logic new_fits = (new_mode == MODE_LS1) ? ls1_clk_ok :
                        (new_mode == MODE_LS2) ? ls2_clk_ok : 1'b0;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RD_ZERO;
    if (hit_opc) begin
      rd_mux[OPC_MODE_LSB +: 3] = power_mode_q;
      rd_mux[OPC_EFF_BIT] = lp_effective_q;
    end else if (hit_sby) begin
      rd_mux[SBY_SEL_LSB +: 2] = sby_sel_q;
      rd_mux[SBY_RAM0_BIT] = ram0_keep_q;
    end else if (hit_stat) begin
      rd_mux[STAT_STATE_LSB +: 3] = state_q;
      rd_mux[STAT_PE_BIT] = flash_pe_inhibit_q;
      rd_mux[STAT_EFF_BIT] = lp_effective_q;
    end
  end

  // Answer is fixed at one access cycle, so pready is set at setup.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RD_ZERO;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : RD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Operating power control
  // ----------------------------------------------------------------
  // Codes other than the three defined ones are dropped, keeping the
  // old mode, since an undefined mode has no defined clock ceiling.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      power_mode_q <= RST_MODE;
      lp_effective_q <= 1'b0;
      flash_pe_inhibit_q <= 1'b0;
    end else if (wr_opc && mode_legal) begin
      power_mode_q <= new_mode;                              // [R1]
      lp_effective_q <= new_fits;                            // [R3]
      flash_pe_inhibit_q <= (new_mode != MODE_HS);           // [R2]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sby_sel_q <= RST_SBY_SEL;
      ram0_keep_q <= RST_RAM0_KEEP;
    end else if (wr_sby) begin
      sby_sel_q <= pwdata[SBY_SEL_LSB +: 2];
      ram0_keep_q <= pwdata[SBY_RAM0_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Standby sequencer
  // ----------------------------------------------------------------
  wire logic run_irq = (state_q == ST_RUN) && irq_req && gie;
  wire logic shallow = (state_q == ST_SLEEP) || (state_q == ST_AMCS)
                    || (state_q == ST_SSTBY);
  wire logic wake_irq = shallow && irq_req;
  wire logic deep_irq = (state_q == ST_DSTBY) && irq_req;
  wire pm_state_t sel_state = (sby_sel_q == SBY_SLEEP) ? ST_SLEEP :
                              (sby_sel_q == SBY_AMCS) ? ST_AMCS :
                              (sby_sel_q == SBY_SSTBY) ? ST_SSTBY : ST_DSTBY;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: begin
        if (wait_exec && !run_irq) begin
          state_d = sel_state;                               // [R5]
        end
      end
      ST_SLEEP, ST_AMCS, ST_SSTBY: begin
        if (irq_req) begin
          state_d = ST_RUN;                                  // [R6]
        end
      end
      ST_DSTBY: begin
        state_d = ST_DSTBY;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Deep standby leaves only through reset, so its request is held
  // until the system reset arrives and clears it.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
      irq_accept_q <= 1'b0;
      gie_clear_q <= 1'b0;
      deep_reset_req_q <= 1'b0;
    end else begin
      state_q <= state_d;
      irq_accept_q <= run_irq || wake_irq;                   // [R6]
      gie_clear_q <= run_irq || wake_irq;                    // [R14]
      deep_reset_req_q <= deep_reset_req_q || deep_irq;      // [R6]
    end
  end

  // ----------------------------------------------------------------
  // Domain gates
  // ----------------------------------------------------------------
  pm_gate_if gi ();
  assign gi.state = state_q;
  assign gi.ram0_keep = ram0_keep_q;

  gate_decode u_dec (
    .clk(clk),
    .rst_b(rst_b),
    .g(gi.dec)
  );

  assign cpu_stop = gi.cpu_stop;
  assign hoco_stop = gi.hoco_stop;
  assign loco_stop = gi.loco_stop;
  assign pll_stop = gi.pll_stop;
  assign ram1_stop = gi.ram1_stop;
  assign ram0_stop = gi.ram0_stop;
  assign ram1_lost = gi.ram1_lost;
  assign ram0_lost = gi.ram0_lost;
  assign periph_stop = gi.periph_stop;
  assign io_hold = gi.io_hold;
  assign system_watchdog_freeze = gi.system_watchdog_freeze;
  assign independent_watchdog_stop = gi.independent_watchdog_stop;
  assign eight_bit_timer_freeze = gi.eight_bit_timer_freeze;
  assign monitors_on = gi.monitors_on;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_mode_sel;
    wr_opc && mode_legal |=> power_mode_q == $past(new_mode);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode not taken"); // [R1]

  property p_lp_eff;
    wr_opc && mode_legal |=> lp_effective_q == $past(new_fits);
  endproperty
  a_lp_eff: assert property (p_lp_eff) else $error("effect wrong"); // [R3]

  property p_enter;
    state_q == ST_RUN && wait_exec && !run_irq |=> state_q == $past(sel_state);
  endproperty
  a_enter: assert property (p_enter) else $error("no standby entry"); // [R5]

  property p_no_enter;
    state_q == ST_RUN && !wait_exec |=> state_q == ST_RUN;
  endproperty
  a_no_enter: assert property (p_no_enter) else $error("entry w/o wait"); // [R5]

  property p_wake;
    wake_irq |=> state_q == ST_RUN && irq_accept_q && gie_clear_q;
  endproperty
  a_wake: assert property (p_wake) else $error("shallow wake failed"); // [R6]

  property p_deep;
    deep_irq |=> deep_reset_req_q && state_q == ST_DSTBY;
  endproperty
  a_deep: assert property (p_deep) else $error("deep wake failed"); // [R6]

  property p_cpu;
    state_q != ST_RUN |=> cpu_stop && system_watchdog_freeze;
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu not stopped"); // [R8]

  property p_osc;
    state_q == ST_SSTBY |=> hoco_stop && pll_stop && loco_stop
      && eight_bit_timer_freeze;
  endproperty
  a_osc: assert property (p_osc) else $error("osc not stopped"); // [R9]

  property p_ram;
    state_q == ST_SLEEP |=> !ram1_stop && !ram0_stop && !periph_stop;
  endproperty
  a_ram: assert property (p_ram) else $error("sleep ram stopped"); // [R10]

  property p_pins;
    state_q == ST_AMCS |=> io_hold && periph_stop
      && !independent_watchdog_stop;
  endproperty
  a_pins: assert property (p_pins) else $error("pins not held"); // [R11]

  property p_mon;
    state_q != ST_RUN |=> monitors_on;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor off"); // [R12]

  property p_gie;
    run_irq |=> gie_clear_q ##1 (!gie_clear_q || $past(run_irq));
  endproperty
  a_gie: assert property (p_gie) else $error("enable not cleared"); // [R14]

  c_sleep_wake: cover property (state_q == ST_SLEEP ##1 state_q == ST_RUN);
  c_deep: cover property (deep_irq ##1 deep_reset_req_q);
  c_ls2_eff: cover property (wr_opc && new_mode == MODE_LS2 && new_fits);
  c_sstby: cover property (state_q == ST_RUN ##1 state_q == ST_SSTBY);
endmodule

// ### src/lpm_pkg.sv
// Package of constants and types for the power-mode controller.
package lpm_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_OPC = 8'h00;
  localparam logic [7:0] OFS_SBY = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam int OPC_MODE_LSB = 0;
  localparam int OPC_EFF_BIT = 4;
  localparam int SBY_SEL_LSB = 0;
  localparam int SBY_RAM0_BIT = 2;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PE_BIT = 3;
  localparam int STAT_EFF_BIT = 4;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_HS = 3'h0;
  localparam logic [2:0] MODE_LS1 = 3'h6;
  localparam logic [2:0] MODE_LS2 = 3'h7;
  localparam logic [1:0] SBY_SLEEP = 2'h0;
  localparam logic [1:0] SBY_AMCS = 2'h1;
  localparam logic [1:0] SBY_SSTBY = 2'h2;
  localparam logic [1:0] SBY_DSTBY = 2'h3;
  localparam logic [2:0] RST_MODE = MODE_HS;
  localparam logic [1:0] RST_SBY_SEL = SBY_SLEEP;
  localparam logic RST_RAM0_KEEP = 1'b1;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SLEEP = 3'h1,
    ST_AMCS = 3'h3,
    ST_SSTBY = 3'h2,
    ST_DSTBY = 3'h6
  } pm_state_t;

endpackage

// ### src/pm_gate_if.sv
// Interface between the mode sequencer and the domain gate decoder.
`timescale 1ns/1ps
interface pm_gate_if;
  import lpm_pkg::*;
  pm_state_t state;
  logic ram0_keep;
  logic cpu_stop;
  logic hoco_stop;
  logic loco_stop;
  logic pll_stop;
  logic ram1_stop;
  logic ram0_stop;
  logic ram1_lost;
  logic ram0_lost;
  logic periph_stop;
  logic io_hold;
  logic system_watchdog_freeze;
  logic independent_watchdog_stop;
  logic eight_bit_timer_freeze;
  logic monitors_on;

  modport ctrl (
    output state, ram0_keep,
    input cpu_stop, hoco_stop, loco_stop, pll_stop, ram1_stop, ram0_stop,
    input ram1_lost, ram0_lost, periph_stop, io_hold, system_watchdog_freeze,
    input independent_watchdog_stop, eight_bit_timer_freeze, monitors_on
  );
  modport dec (
    input state, ram0_keep,
    output cpu_stop, hoco_stop, loco_stop, pll_stop, ram1_stop, ram0_stop,
    output ram1_lost, ram0_lost, periph_stop, io_hold, system_watchdog_freeze,
    output independent_watchdog_stop, eight_bit_timer_freeze, monitors_on
  );
endinterface

// ### src/gate_decode.sv
// Registered decode of standby state into clock and domain gates.
`timescale 1ns/1ps
module gate_decode (
  input wire logic clk,
  input wire logic rst_b,
  pm_gate_if.dec g
);
  import lpm_pkg::*;

  // ----------------------------------------------------------------
  // State classes
  // ----------------------------------------------------------------
  wire logic any_sby = (g.state != ST_RUN);
  wire logic mid_sby = (g.state == ST_AMCS) || (g.state == ST_SSTBY);
  wire logic deep_sby = (g.state == ST_SSTBY) || (g.state == ST_DSTBY);
  wire logic is_deep = (g.state == ST_DSTBY);

  // Gates are registered so every top-level output leaves a flip-flop.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      g.cpu_stop <= 1'b0;
      g.hoco_stop <= 1'b0;
      g.loco_stop <= 1'b0;
      g.pll_stop <= 1'b0;
      g.ram1_stop <= 1'b0;
      g.ram0_stop <= 1'b0;
      g.ram1_lost <= 1'b0;
      g.ram0_lost <= 1'b0;
      g.periph_stop <= 1'b0;
      g.io_hold <= 1'b0;
      g.system_watchdog_freeze <= 1'b0;
      g.independent_watchdog_stop <= 1'b0;
      g.eight_bit_timer_freeze <= 1'b0;
      g.monitors_on <= 1'b1;
    end else begin
      g.cpu_stop <= any_sby;                                  // [R8]
      g.hoco_stop <= deep_sby;                                // [R9]
      g.loco_stop <= deep_sby;                                // [R9]
      g.pll_stop <= deep_sby;                                 // [R9]
      g.ram1_stop <= mid_sby || is_deep;                      // [R10]
      g.ram0_stop <= mid_sby || is_deep;                      // [R10]
      g.ram1_lost <= is_deep;                                 // [R10]
      g.ram0_lost <= is_deep && !g.ram0_keep;                 // [R10]
      g.periph_stop <= mid_sby || is_deep;                    // [R11]
      g.io_hold <= any_sby && (g.state != ST_SLEEP);          // [R11]
      g.system_watchdog_freeze <= any_sby; // [R13]
      g.independent_watchdog_stop <= is_deep; // [R13]
      g.eight_bit_timer_freeze <= deep_sby; // [R13]
      g.monitors_on <= 1'b1;                                  // [R12]
    end
  end
endmodule

// ### verification/cpu_model.sv
// Behavioural CPU core that issues the wait instruction to the controller.
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk,
  input wire logic gie_clear_q,
  output logic wait_exec,
  output logic gie,
  output logic ls1_clk_ok,
  output logic ls2_clk_ok
);
  initial begin
    wait_exec = 1'b0;
    gie = 1'b0;
    ls1_clk_ok = 1'b0;
    ls2_clk_ok = 1'b0;
  end
  // The core drops its enable when told, as taking an interrupt does.
  always @(posedge clk) begin
    if (gie_clear_q === 1'b1) begin
      gie <= 1'b0;
    end
  end
  task automatic clocks(input logic ok);
    ls1_clk_ok <= ok;
    ls2_clk_ok <= ok;
  endtask
  task automatic set_gie();
    gie <= 1'b1;
  endtask
  // Careless software (bare) leaves its enable up, so a wake can race.
  task automatic exec_wait(input logic bare);
    if (!bare) begin
      gie <= 1'b0;
    end
    wait_exec <= 1'b1;
    @(posedge clk);
    wait_exec <= 1'b0;
  endtask
endmodule

// ### verification/test_low_power_mode_control.sv
// Self-checking testbench of the power-mode controller.
`timescale 1ns/1ps
module test_low_power_mode_control;
  import lpm_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, irq_req, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic wait_exec, gie, ls1_clk_ok, ls2_clk_ok, monitors_on;
  logic [2:0] power_mode_q;
  logic lp_effective_q, flash_pe_inhibit_q, irq_accept_q, gie_clear_q;
  logic deep_reset_req_q, cpu_stop, hoco_stop, loco_stop, pll_stop;
  logic ram1_stop, ram0_stop, ram1_lost, ram0_lost, periph_stop, io_hold;
  logic system_watchdog_freeze, independent_watchdog_stop;
  logic eight_bit_timer_freeze;
  logic [12:0] gv;
  int n_fail = 0;
  int tests_run = 0;
  int n;
  assign gv = {cpu_stop, hoco_stop, loco_stop, pll_stop, ram1_stop,
    ram0_stop, ram1_lost, ram0_lost, periph_stop, io_hold,
    system_watchdog_freeze, independent_watchdog_stop,
    eight_bit_timer_freeze};
  low_power_mode_control dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wait_exec(wait_exec),
    .irq_req(irq_req),
    .gie(gie),
    .ls1_clk_ok(ls1_clk_ok),
    .ls2_clk_ok(ls2_clk_ok),
    .power_mode_q(power_mode_q),
    .lp_effective_q(lp_effective_q),
    .flash_pe_inhibit_q(flash_pe_inhibit_q),
    .irq_accept_q(irq_accept_q),
    .gie_clear_q(gie_clear_q),
    .deep_reset_req_q(deep_reset_req_q),
    .cpu_stop(cpu_stop),
    .hoco_stop(hoco_stop),
    .loco_stop(loco_stop),
    .pll_stop(pll_stop),
    .ram1_stop(ram1_stop),
    .ram0_stop(ram0_stop),
    .ram1_lost(ram1_lost),
    .ram0_lost(ram0_lost),
    .periph_stop(periph_stop),
    .io_hold(io_hold),
    .system_watchdog_freeze(system_watchdog_freeze),
    .independent_watchdog_stop(independent_watchdog_stop),
    .eight_bit_timer_freeze(eight_bit_timer_freeze),
    .monitors_on(monitors_on)
  );
  cpu_model cpu_u (
    .clk(clk),
    .gie_clear_q(gie_clear_q),
    .wait_exec(wait_exec),
    .gie(gie),
    .ls1_clk_ok(ls1_clk_ok),
    .ls2_clk_ok(ls2_clk_ok)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tmo();
    if (n >= 20) begin
      n_fail++;
      results();
    end
  endtask
  // APB master: holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle cycle follows so the next setup never re-drives psel at once.
    @(posedge clk);
    tmo();
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, OFS_OPC, 32'h0000_0000);
    chk("opc", 32'h0000_0000, rd);
    apb(1'b0, OFS_SBY, 32'h0000_0000);
    chk("sby", 32'h0000_0004, rd);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk("stat", 32'h0000_0000, rd);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0000_0000, er});
    apb(1'b1, 8'h40, 32'h0000_0007);
    chk("unmapped_wr", 32'h0000_0001, {31'h0000_0000, er});
    apb(1'b0, OFS_OPC, 32'h0000_0000);
    chk("opc_kept", 32'h0000_0000, rd);
    chk("mon", 32'h0000_0001, monitors_on);
  endtask
  // Every legal code, with and without the clocks fitting.
  task automatic t_modes();
    logic [2:0] c [3];
    logic [2:0] m;
    logic e;
    c = '{MODE_HS, MODE_LS1, MODE_LS2};
    for (int ok = 0; ok < 2; ok++) begin
      cpu_u.clocks(ok[0]);
      foreach (c[i]) begin
        m = c[i];
        e = (m != MODE_HS) && ok[0];
        apb(1'b1, OFS_OPC, {29'h0000_0000, m});
        apb(1'b0, OFS_OPC, 32'h0000_0000);
        chk("opc_rd", {27'h0000_000, e, 1'b0, m}, rd);
        chk("mode", m, power_mode_q);
        chk("pe_inh", m != MODE_HS, flash_pe_inhibit_q);
        chk("eff", e, lp_effective_q);
        apb(1'b0, OFS_STAT, 32'h0000_0000);
        chk("stat_eff", {e, m != MODE_HS}, rd[4:3]);
      end
    end
    apb(1'b1, OFS_OPC, 32'h0000_0003);
    apb(1'b0, OFS_OPC, 32'h0000_0000);
    chk("bad_code", MODE_LS2, rd[2:0]);
  endtask
  // Enter one standby kind, check its gates, then wake it.
  task automatic t_sby(input logic [1:0] sel, input pm_state_t st,
      input logic keep, input logic [12:0] eg);
    apb(1'b1, OFS_SBY, {29'h0000_0000, keep, sel});
    cpu_u.exec_wait(1'b0);
    repeat (2) @(posedge clk);
    chk("gates", eg, gv);
    chk("mon_sby", 32'h0000_0001, monitors_on);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk("state", st, rd[2:0]);
    irq_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq_accept_q !== 1'b1 && deep_reset_req_q !== 1'b1 && n < 20);
    tmo();
    chk("deep_req", sel == SBY_DSTBY, deep_reset_req_q);
    chk("gie_clr", sel != SBY_DSTBY, gie_clear_q);
    chk("accept", sel != SBY_DSTBY, irq_accept_q);
    irq_req <= 1'b0;
    repeat (3) @(posedge clk);
    if (sel == SBY_DSTBY) begin
      chk("deep_hold", 32'h0000_0001, deep_reset_req_q);
      do_reset();
      chk("deep_clr", 32'h0000_0000, deep_reset_req_q);
    end
    chk("gates_off", 13'h0000, gv);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk("state_run", ST_RUN, rd[2:0]);
  endtask
  // A pending enabled interrupt beats the wait instruction.
  task automatic t_race();
    cpu_u.set_gie();
    irq_req <= 1'b1;
    cpu_u.exec_wait(1'b1);
    n = 0;
    while (irq_accept_q !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    tmo();
    chk("race_clr", 32'h0000_0001, gie_clear_q);
    irq_req <= 1'b0;
    repeat (2) @(posedge clk);
    chk("gie_low", 32'h0000_0000, gie);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk("race_st", ST_RUN, rd[2:0]);
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    irq_req = 1'b0;
    do_reset();
    t_reset();
    t_modes();
    t_sby(SBY_SLEEP, ST_SLEEP, 1'b0, 13'h1004);
    t_sby(SBY_AMCS, ST_AMCS, 1'b0, 13'h119c);
    t_sby(SBY_SSTBY, ST_SSTBY, 1'b0, 13'h1f9d);
    t_sby(SBY_DSTBY, ST_DSTBY, 1'b0, 13'h1fff);
    t_sby(SBY_DSTBY, ST_DSTBY, 1'b1, 13'h1fdf);
    t_race();
    results();
  end
endmodule
